// [hdl/pws_supervisor.sv]
`timescale 1ns/10ps
// Contract
// - Valid press raises power-hold for minimum time
// - No shutdown-request high in window: hold low
// - Shutdown-request low in normal run drops hold; the code drops it only while the button is released
// - Button held ten seconds drops hold
// - Global reset command drops hold
// - Button input is active low
// - Request low forces bucks off, plus one second
// - Request ignored during turn-on blanking window
// - Watchdog failure pulls fault low 200 ms
// - Kick edge needed every 1.5 s
// - Each buck has active-high enable
// - Tied feedback makes slave; groups up to four
// - All intervals use one common time base
// - Data line driven only during read-back
// - Press valid after 200 ms low
// - Request low debounced 50 ms
module pws_supervisor #(
  parameter int TICK_CLKS = pws_pkg::CLKS_PER_TICK
) (
  // Clock and reset.
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  // Pushbutton, shutdown request, watchdog kick.
  input wire logic BUTTON_N_IN,
  input wire logic SHUTDOWN_REQ_N_IN,
  input wire logic TIMER_KICK_IN,
  // Serial port side: decoded global reset and read-back bit.
  input wire logic RESET_ALL_IN,
  input wire logic READBACK_ACTIVE_IN,
  input wire logic READBACK_BIT_IN,
  // Regulator enables and feedback straps.
  input wire logic [pws_pkg::NUM_BUCKS-1:0] BUCK_ENABLE_IN,
  input wire logic [pws_pkg::NUM_BUCKS-1:0] BUCK_FEEDBACK_TIED_IN,
  // Open-drain power-hold and fault pins.
  output logic POWER_HOLD_OUT,
  output logic POWER_HOLD_OE_OUT,
  output logic TIMER_FAULT_N_OUT,
  output logic TIMER_FAULT_OE_OUT,
  // Open-drain serial data pin.
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // Regulator run requests.
  output logic [pws_pkg::NUM_BUCKS-1:0] BUCK_RUN_OUT
);
  import pws_pkg::*;

  localparam int PRESC_W = $clog2(TICK_CLKS);

  // Finds the master of a regulator; an over-long chain leaves it independent.
  function automatic int master_of(input logic [NUM_BUCKS-1:0] tied, input int idx);
    int m;
    m = idx;
    for (int k = 0; k < MAX_GROUP - 1; k++)
    begin
      if (m > 0 && m == idx - k && tied[m])
        m = m - 1;
    end
    if (m > 0 && tied[m])
      m = idx;
    return m;
  endfunction : master_of

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic kick_prev_q;
  logic [PRESC_W-1:0] presc_q;
  logic tick_q;
  logic [MS_W-1:0] btn_ms_q;
  logic [MS_W-1:0] kill_ms_q;
  logic [MS_W-1:0] win_ms_q;
  logic [MS_W-1:0] hold_ms_q;
  logic [MS_W-1:0] wd_ms_q;
  logic [MS_W-1:0] fault_ms_q;
  logic armed_q;
  logic kill_seen_q;
  logic pwr_q;
  logic fault_n_q;
  logic sda_oe_q;
  logic cfg_done_q;
  logic [NUM_BUCKS-1:0] tied_q;
  logic [NUM_BUCKS-1:0] run_q;
  pws_state_t state_q;
  logic btn_n;
  logic kill_n;
  logic kick_edge;
  logic press_done;
  logic button_off;
  logic kill_done;
  logic win_done;
  logic kill_force;
  logic bucks_off;
  logic wd_fail;

  // Two-flop synchronisers; idle levels avoid a false press or request at reset.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      sync1_q <= 3'h3;
      sync2_q <= 3'h3;
      kick_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {TIMER_KICK_IN, SHUTDOWN_REQ_N_IN, BUTTON_N_IN};
      sync2_q <= sync1_q;
      kick_prev_q <= sync2_q[2];
    end
  end

  // Decoded conditions, all taken from the second synchroniser stage.
  assign btn_n = sync2_q[0];
  assign kill_n = sync2_q[1];
  assign kick_edge = sync2_q[2] ^ kick_prev_q;
  assign press_done = !btn_n && btn_ms_q >= PRESS_ON_TICKS;
  assign button_off = !btn_n && btn_ms_q >= BUTTON_OFF_TICKS;
  assign kill_done = btn_n && kill_ms_q >= KILL_DEB_TICKS;
  assign win_done = win_ms_q >= BLANK_TICKS;
  assign kill_force = !kill_n && state_q != PWS_BLANK;
  assign bucks_off = kill_force || hold_ms_q != '0;
  assign wd_fail = state_q != PWS_OFF && !kick_edge && tick_q && wd_ms_q == KICK_GAP_TICKS;

  // Prescaler standing in for the timing capacitor.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      presc_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= presc_q == PRESC_W'(TICK_CLKS - 1);
      presc_q <= (presc_q == PRESC_W'(TICK_CLKS - 1)) ? '0 : presc_q + 1'b1;
    end
  end

  // Button low time; restarts at turn-on so the turn-on press is not read as a hold.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      btn_ms_q <= '0;
    else if (btn_n || (state_q == PWS_OFF && armed_q && press_done))
      btn_ms_q <= '0;
    else if (tick_q && btn_ms_q != BUTTON_OFF_TICKS)
      btn_ms_q <= btn_ms_q + 1'b1;
  end

  // A new turn-on needs the button released first.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      armed_q <= 1'b0;
    else if (btn_n)
      armed_q <= 1'b1;
    else if (state_q != PWS_OFF || RESET_ALL_IN)
      armed_q <= 1'b0;
  end

  // Request-low debounce, only counted in normal operation.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      kill_ms_q <= '0;
    else if (kill_n || state_q != PWS_RUN)
      kill_ms_q <= '0;
    else if (tick_q && kill_ms_q != KILL_DEB_TICKS)
      kill_ms_q <= kill_ms_q + 1'b1;
  end

  // Blanking window timer and record of the host raising its request.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      win_ms_q <= '0;
      kill_seen_q <= 1'b0;
    end
    else if (state_q != PWS_BLANK)
    begin
      win_ms_q <= '0;
      kill_seen_q <= 1'b0;
    end
    else
    begin
      if (tick_q && !win_done)
        win_ms_q <= win_ms_q + 1'b1;
      if (kill_n)
        kill_seen_q <= 1'b1;
    end
  end

  // Power-hold sequencer; the global reset overrides everything.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      state_q <= PWS_OFF;
      pwr_q <= 1'b0;
    end
    else if (RESET_ALL_IN)
    begin
      state_q <= PWS_OFF;
      pwr_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        PWS_OFF:
          if (armed_q && press_done)
          begin
            state_q <= PWS_BLANK;
            pwr_q <= 1'b1;
          end
        PWS_BLANK:
          if (win_done)
          begin
            state_q <= kill_seen_q ? PWS_RUN : PWS_OFF;
            pwr_q <= kill_seen_q;
          end
        PWS_RUN:
          if (button_off || kill_done)
          begin
            state_q <= PWS_OFF;
            pwr_q <= 1'b0;
          end
      endcase
    end
  end

  // Regulator hold-off runs a further second after the request returns high.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      hold_ms_q <= '0;
    else if (kill_force)
      hold_ms_q <= BUCK_HOLD_TICKS;
    else if (tick_q && hold_ms_q != '0)
      hold_ms_q <= hold_ms_q - 1'b1;
  end

  // Watchdog gap timer, armed only while the system is on.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      wd_ms_q <= '0;
    else if (state_q == PWS_OFF || kick_edge || wd_fail)
      wd_ms_q <= '0;
    else if (tick_q)
      wd_ms_q <= wd_ms_q + 1'b1;
  end

  // Fault pulse; a failure during a pulse restarts it.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      fault_ms_q <= '0;
      fault_n_q <= 1'b1;
    end
    else if (wd_fail)
    begin
      fault_ms_q <= FAULT_TICKS;
      fault_n_q <= 1'b0;
    end
    else if (tick_q && fault_ms_q != '0)
    begin
      fault_ms_q <= fault_ms_q - 1'b1;
      fault_n_q <= fault_ms_q == MS_W'(1);
    end
  end

  // Read-back drive; the line is only ever pulled low.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      sda_oe_q <= 1'b0;
    else
      sda_oe_q <= READBACK_ACTIVE_IN && !READBACK_BIT_IN;
  end

  // Straps are caught once after reset; wiring does not change while running.
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      cfg_done_q <= 1'b0;
      tied_q <= '0;
    end
    else if (!cfg_done_q)
    begin
      cfg_done_q <= 1'b1;
      tied_q <= BUCK_FEEDBACK_TIED_IN;
    end
  end

  // Each regulator follows the enable of its group master.
  generate
    for (genvar i = 0; i < NUM_BUCKS; i++)
    begin : g_buck
      always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN)
      begin
        if (!RSTN_IN)
          run_q[i] <= 1'b0;
        else
          run_q[i] <= cfg_done_q && !bucks_off && BUCK_ENABLE_IN[master_of(tied_q, i)];
      end
    end
  endgenerate

  assign POWER_HOLD_OUT = pwr_q;
  assign POWER_HOLD_OE_OUT = !pwr_q;
  assign TIMER_FAULT_N_OUT = fault_n_q;
  assign TIMER_FAULT_OE_OUT = !fault_n_q;
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = sda_oe_q;
  assign BUCK_RUN_OUT = run_q;

  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  sequence s_press_taken;
    state_q == PWS_OFF && armed_q && press_done && !RESET_ALL_IN;
  endsequence
  sequence s_hold_on;
    pwr_q && state_q == PWS_BLANK;
  endsequence

  property p_press_on;
    s_press_taken |=> s_hold_on;
  endproperty
  a_press_on: assert property (p_press_on) else $error("press did not raise hold");

  property p_window_fail;
    state_q == PWS_BLANK && win_done && !kill_seen_q && !RESET_ALL_IN |=> !pwr_q && state_q == PWS_OFF;
  endproperty
  a_window_fail: assert property (p_window_fail) else $error("hold stayed after window");

  property p_kill_off;
    state_q == PWS_RUN && kill_done && !RESET_ALL_IN |=> !pwr_q;
  endproperty
  a_kill_off: assert property (p_kill_off) else $error("request low did not drop hold");

  property p_button_off;
    state_q == PWS_RUN && button_off |=> !pwr_q;
  endproperty
  a_button_off: assert property (p_button_off) else $error("long press did not drop hold");

  property p_reset_all;
    RESET_ALL_IN |=> !POWER_HOLD_OUT && POWER_HOLD_OE_OUT;
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("global reset kept hold");

  property p_rise_low;
    $rose(pwr_q) |-> $past(btn_n) == 1'b0 && $past(btn_ms_q) >= PRESS_ON_TICKS;
  endproperty
  a_rise_low: assert property (p_rise_low) else $error("hold rose without low press");

  property p_bucks_off;
    kill_force |=> run_q == '0 && hold_ms_q == BUCK_HOLD_TICKS ##1 run_q == '0;
  endproperty
  a_bucks_off: assert property (p_bucks_off) else $error("bucks ran during hold-off");

  property p_blank_hold;
    state_q == PWS_BLANK && !win_done && !RESET_ALL_IN |=> pwr_q;
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("hold lost in blanking");

  property p_fault_pulse;
    wd_fail |=> !TIMER_FAULT_N_OUT [*8] ##0 fault_ms_q != '0;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault pulse too short");

  property p_kick_clear;
    kick_edge |=> wd_ms_q == '0;
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("kick did not restart timer");

  property p_slave_follow;
    cfg_done_q && !bucks_off |=> run_q[1] == $past(BUCK_ENABLE_IN[master_of(tied_q, 1)]);
  endproperty
  a_slave_follow: assert property (p_slave_follow) else $error("slave not following master");

  property p_tick_only;
    !tick_q |=> $stable(win_ms_q) || state_q != PWS_BLANK;
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("window moved without tick");

  property p_sda;
    SDA_OE_OUT |-> $past(READBACK_ACTIVE_IN);
  endproperty
  a_sda: assert property (p_sda) else $error("data line driven outside read-back");

  property p_sync;
    ##2 sync2_q[0] == $past(BUTTON_N_IN, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("button sync depth wrong");

endmodule : pws_supervisor

// [hdl/pws_pkg.sv]
package pws_pkg;

  // Core clock and the millisecond tick that stands in for the timing capacitor.
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int CLKS_PER_TICK = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_PERIOD_MS = TICK_PERIOD_NS / 1_000_000;

  // Nominal intervals, each in its own unit.
  localparam int PRESS_ON_MS = 200;
  localparam int BLANK_WINDOW_S = 10;
  localparam int BUTTON_OFF_S = 10;
  localparam int KILL_DEBOUNCE_MS = 50;
  localparam int BUCK_HOLD_S = 1;
  localparam int KICK_GAP_MS = 1500;
  localparam int FAULT_PULSE_MS = 200;

  // Millisecond counters are this wide; ten seconds must fit.
  localparam int MS_W = 14;

  // Interval lengths in ticks.
  localparam logic [MS_W-1:0] PRESS_ON_TICKS = MS_W'(PRESS_ON_MS / TICK_PERIOD_MS);
  localparam logic [MS_W-1:0] BLANK_TICKS = MS_W'(BLANK_WINDOW_S * 1000 / TICK_PERIOD_MS);
  localparam logic [MS_W-1:0] BUTTON_OFF_TICKS = MS_W'(BUTTON_OFF_S * 1000 / TICK_PERIOD_MS);
  localparam logic [MS_W-1:0] KILL_DEB_TICKS = MS_W'(KILL_DEBOUNCE_MS / TICK_PERIOD_MS);
  localparam logic [MS_W-1:0] BUCK_HOLD_TICKS = MS_W'(BUCK_HOLD_S * 1000 / TICK_PERIOD_MS);
  localparam logic [MS_W-1:0] KICK_GAP_TICKS = MS_W'(KICK_GAP_MS / TICK_PERIOD_MS);
  localparam logic [MS_W-1:0] FAULT_TICKS = MS_W'(FAULT_PULSE_MS / TICK_PERIOD_MS);

  // Regulator count and largest combined group.
  localparam int NUM_BUCKS = 8;
  localparam int MAX_GROUP = 4;

  // Power-hold sequencing states.
  typedef enum logic [1:0] {PWS_OFF, PWS_BLANK, PWS_RUN} pws_state_t;

endpackage : pws_pkg

// [test/pws_host_model.sv]
`timescale 1ns/10ps
// Host and its supply: powered by the power-hold pin, it answers on the request and kick pins.
module pws_host_model #(
  parameter int RESP_CLKS = 200,
  parameter int KICK_CLKS = 2800
) (
  // Clock and power.
  input wire logic clk_in,
  input wire logic power_hold_in,
  // Bench control.
  input wire logic host_en_in,
  input wire logic kick_en_in,
  // Pins toward the supervisor.
  output logic shutdown_req_n_out = 1'b0,
  output logic timer_kick_out = 1'b0
);
  int up_cnt = 0;
  int kick_cnt = 0;
  // The host boots a while after power-hold rises and loses power with it, so the request drops too.
  always_ff @(posedge clk_in)
  begin
    up_cnt <= power_hold_in ? up_cnt + 1 : 0;
    shutdown_req_n_out <= host_en_in && (up_cnt >= RESP_CLKS);
  end
  // Kicks land just inside the allowed gap, so a watchdog that counts short would trip.
  always_ff @(posedge clk_in)
  begin
    kick_cnt <= (kick_en_in && kick_cnt < KICK_CLKS - 1) ? kick_cnt + 1 : 0;
    if (kick_en_in && kick_cnt == KICK_CLKS - 1)
      timer_kick_out <= !timer_kick_out;
  end
endmodule : pws_host_model

// [test/pws_supervisor_bench.sv]
`timescale 1ns/10ps
module pws_supervisor_bench;
  import pws_pkg::*;
  // A short tick keeps the ten-second windows to twenty thousand cycles.
  localparam int TK = 2;
  localparam logic [7:0] STRAPS = 8'hf2;
  localparam logic [7:0] EN_V [4] = '{8'h01, 8'h08, 8'h80, 8'hf6};
  localparam logic [7:0] RUN_V [4] = '{8'h03, 8'h78, 8'h80, 8'h84};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic button_n = 1'b1;
  logic reset_all = 1'b0;
  logic rb_act = 1'b0;
  logic rb_bit = 1'b0;
  logic [NUM_BUCKS-1:0] en = 8'h00;
  logic host_en = 1'b0;
  logic kick_en = 1'b0;
  logic req_n, kick, hold, hold_oe, fault_n, fault_oe, sda, sda_oe, kick_prev;
  logic [NUM_BUCKS-1:0] run;
  int errors = 0;
  int n_tests = 0;
  int kick_age = 0;
  int n;

  pws_supervisor #(.TICK_CLKS(TK)) pws_supervisor_inst (
    .CORE_CLK_IN(clk), .RSTN_IN(rst_n), .BUTTON_N_IN(button_n), .SHUTDOWN_REQ_N_IN(req_n),
    .TIMER_KICK_IN(kick), .RESET_ALL_IN(reset_all), .READBACK_ACTIVE_IN(rb_act),
    .READBACK_BIT_IN(rb_bit), .BUCK_ENABLE_IN(en), .BUCK_FEEDBACK_TIED_IN(STRAPS),
    .POWER_HOLD_OUT(hold), .POWER_HOLD_OE_OUT(hold_oe), .TIMER_FAULT_N_OUT(fault_n),
    .TIMER_FAULT_OE_OUT(fault_oe), .SDA_OUT(sda), .SDA_OE_OUT(sda_oe), .BUCK_RUN_OUT(run));

  pws_host_model #(.RESP_CLKS(200), .KICK_CLKS(2800)) pws_host_model_inst (
    .clk_in(clk), .power_hold_in(!hold_oe), .host_en_in(host_en), .kick_en_in(kick_en),
    .shutdown_req_n_out(req_n), .timer_kick_out(kick));

  // Clock at 40 MHz.
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Age of the last kick edge, so the watchdog gap is judged from the pin itself.
  always @(negedge clk)
  begin
    kick_age <= (kick !== kick_prev) ? 0 : kick_age + 1;
    kick_prev <= kick;
  end

  task automatic print_verdict;
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk

  task automatic chk_rng(input string name, input int v, input int lo, input int hi);
    n_tests++;
    if (v < lo || v > hi)
    begin
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, v);
      errors++;
    end
  endtask : chk_rng

  function automatic logic pick(input int which);
    case (which)
      0: return hold;
      1: return fault_n;
      default: return run[0];
    endcase
  endfunction : pick

  // Counts falling edges until the chosen output reaches val; -1 if it never did.
  task automatic wait_sig(input string name, input int which, input logic val, input int max,
                          input bit must, output int cnt);
    cnt = -1;
    for (int i = 0; i < max; i++)
    begin
      @(negedge clk);
      if (pick(which) === val)
      begin
        cnt = i + 1;
        break;
      end
    end
    if (must && cnt < 0)
    begin
      $display("[FAIL] %s expected %b seen timeout", name, val);
      errors++;
      print_verdict();
    end
  endtask : wait_sig

  // A held press must wait out the debounce before power-hold rises.
  task automatic press;
    button_n = 1'b0;
    wait_sig("hold rise", 0, 1'b1, 500, 1, n);
    chk_rng("press to hold", n, 398, 410);
    chk("hold oe", 8'h00, {7'h00, hold_oe});
  endtask : press

  task automatic t_silent_host;
    host_en = 1'b0;
    press();
    button_n = 1'b1;
    wait_sig("hold drop", 0, 1'b0, 20100, 1, n);
    chk_rng("window without request", n, 19990, 20012);
  endtask : t_silent_host

  // Straps tie 2, 5, 6, 7 and 8; the fifth member of the long chain runs on its own.
  task automatic t_bucks;
    for (int i = 0; i < 4; i++)
    begin
      en = EN_V[i];
      repeat (3) @(negedge clk);
      chk("buck run", RUN_V[i], run);
    end
  endtask : t_bucks

  task automatic t_sda;
    for (int i = 0; i < 4; i++)
    begin
      rb_act = i[1];
      rb_bit = i[0];
      repeat (2) @(negedge clk);
      chk("sda oe", {7'h00, i[1] & !i[0]}, {7'h00, sda_oe});
      chk("sda level", 8'h00, {7'h00, sda});
    end
    rb_act = 1'b0;
  endtask : t_sda

  task automatic t_watchdog;
    host_en = 1'b1;
    kick_en = 1'b1;
    press();
    button_n = 1'b1;
    wait_sig("fault while kicked", 1, 1'b0, 20100, 0, n);
    chk_rng("fault while kicked", n, -1, -1);
    chk("hold after window", 8'h01, {7'h00, hold});
    t_bucks();
    t_sda();
    kick_en = 1'b0;
    wait_sig("fault fall", 1, 1'b0, 4000, 1, n);
    chk_rng("kick gap", kick_age, 2996, 3012);
    chk("fault oe", 8'h01, {7'h00, fault_oe});
    wait_sig("fault rise", 1, 1'b1, 600, 1, n);
    chk_rng("fault width", n, 396, 404);
  endtask : t_watchdog

  // A request glitch shorter than the debounce stops the bucks but keeps power-hold.
  task automatic t_req_glitch;
    en = 8'h01;
    repeat (4) @(negedge clk);
    host_en = 1'b0;
    repeat (6) @(negedge clk);
    chk("run while request low", 8'h00, run);
    repeat (34) @(negedge clk);
    host_en = 1'b1;
    wait_sig("run back", 2, 1'b1, 2200, 1, n);
    chk_rng("buck hold-off", n, 1996, 2012);
    chk("hold after glitch", 8'h01, {7'h00, hold});
  endtask : t_req_glitch

  task automatic t_req_off;
    host_en = 1'b0;
    wait_sig("hold drop", 0, 1'b0, 300, 1, n);
    chk_rng("request debounce", n, 98, 110);
    chk("run after off", 8'h00, run);
  endtask : t_req_off

  task automatic t_button_hold;
    host_en = 1'b1;
    press();
    wait_sig("hold drop", 0, 1'b0, 20100, 1, n);
    chk_rng("button held", n, 19990, 20012);
    button_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : t_button_hold

  task automatic t_reset_all;
    press();
    button_n = 1'b1;
    reset_all = 1'b1;
    @(negedge clk);
    reset_all = 1'b0;
    wait_sig("reset all", 0, 1'b0, 4, 1, n);
    chk("hold oe after reset all", 8'h01, {7'h00, hold_oe});
  endtask : t_reset_all

  // Main sequence.
  initial
  begin
    repeat (20) @(negedge clk);
    chk("reset hold", 8'h01, {6'h00, hold, hold_oe});
    chk("reset fault", 8'h02, {6'h00, fault_n, fault_oe});
    chk("reset bucks", 8'h00, run);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_silent_host();
    t_watchdog();
    t_req_glitch();
    t_req_off();
    t_button_hold();
    t_reset_all();
    print_verdict();
  end
endmodule : pws_supervisor_bench
